// *** verilog/fan_speed_control_regs.sv ***
// Purpose: register bank and cruise logic for the system and processor fan drives
// Assumes: inputs synchronous to clk_sys; ce low freezes all state
// Notes: index 0 is the system fan, index 1 the processor fan
// Notes on behaviour
// R01 - system fan drive follows its code bits
// R02 - processor fan drive follows its code bits
// R03 - both drive registers reset to all ones
// R04 - config bits 5:4 select processor fan mode
// R05 - config bits 3:2 select system fan mode
// R06 - mode 11 is reserved, does nothing
// R07 - thermal: system target uses bits 6:0
// R08 - speed cruise: system target uses all bits
// R09 - thermal: processor target uses bits 6:0
// R10 - speed cruise: processor target uses all bits
// R11 - thermal: tolerance nibbles are temperature tolerances
// R12 - speed cruise: tolerance nibbles are speed tolerances
// R13 - thermal: system drive never below floor
// R14 - thermal: processor drive never below floor
// R15 - software should program non-zero floor values
// R16 - warn after three minutes hot at full
// R17 - manual mode applies code without adjustment
// R18 - cruise steps code up or down, bounded
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module fan_speed_control_regs
   import fan_ctrl_pkg::*;
#(
   parameter longint STEP_CYCLES = STEP_CYCLES_DEF,
   parameter longint WARN_CYCLES = WARN_CYCLES_DEF
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire reg_req_t bus_req,
   output logic [7:0] rdata,
   input wire fan_meas_t sys_meas,
   input wire fan_meas_t cpu_meas,
   output logic [3:0] system_fan_drive,
   output logic [3:0] processor_fan_drive,
   output logic system_fan_warn,
   output logic processor_fan_warn
);

   localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);
   localparam logic [35:0] WARN_LAST = 36'(WARN_CYCLES - 1);

   // mode field of one fan
   function automatic fan_mode_t mode_of(input logic [7:0] cfg, input int idx);
      logic [1:0] f;
      f = cfg[CFG_SYS_MODE_LSB + 2 * idx +: 2];
      return fan_mode_t'(f);
   endfunction : mode_of

   // up/down decision against target and tolerance: {up, down}
   function automatic logic [1:0] step_dir(input logic [8:0] meas, input logic [8:0] tgt,
                                           input logic [3:0] tol);
      logic [8:0] hi;
      logic up;
      logic dn;
      hi = tgt + {5'h00, tol};
      up = meas > hi;
      dn = (tgt >= {5'h00, tol}) && (meas < tgt - {5'h00, tol});
      return {up, dn};
   endfunction : step_dir

   // write strobe aimed at one offset
   function automatic logic wr_hit(input reg_req_t req, input logic [7:0] a);
      return req.wr && (req.addr == a);
   endfunction : wr_hit

   logic [7:0] drv_q [2];
   logic [7:0] drv_d [2];
   logic [7:0] tgt_q [2];
   logic [7:0] tgt_d [2];
   logic [7:0] flr_q [2];
   logic [7:0] flr_d [2];
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic [7:0] tol_q;
   logic [7:0] tol_d;
   logic [31:0] step_cnt_q;
   logic [31:0] step_cnt_d;
   logic step_q;
   logic step_d;
   logic [35:0] warn_cnt_q [2];
   logic [35:0] warn_cnt_d [2];
   logic [1:0] warn_q;
   logic [1:0] warn_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [3:0] code_q [2];
   logic [3:0] code_d [2];
   fan_mode_t mode [2];
   logic [1:0] dir [2];
   logic [1:0] hot;
   fan_meas_t meas [2];

   assign meas[0] = sys_meas;
   assign meas[1] = cpu_meas;

   // per-fan mode, cruise decision and warning condition
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         mode[i] = mode_of(cfg_q, i); // R04 R05
         hot[i] = 1'b0;
         if (mode[i] == MODE_THERMAL)
         begin
            // top target bit ignored for temperature
            dir[i] = step_dir({2'b00, meas[i].temp}, {2'b00, tgt_q[i][6:0]},
                              tol_q[TOL_SYS_LSB + 4 * i +: 4]); // R07 R09 R11
            hot[i] = (meas[i].temp > tgt_q[i][6:0]) && (drv_q[i][7:4] == CODE_FULL); // R16
         end
         else if (mode[i] == MODE_SPEED)
         begin
            dir[i] = step_dir({1'b0, meas[i].tach}, {1'b0, tgt_q[i]},
                              tol_q[TOL_SYS_LSB + 4 * i +: 4]); // R08 R10 R12
         end
         else
         begin
            dir[i] = 2'b00; // R06 R17
         end
      end
   end

   // step interval timer
   always_comb
   begin
      step_d = 1'b0;
      step_cnt_d = step_cnt_q + 32'h0000_0001;
      if (step_cnt_q >= STEP_LAST)
      begin
         step_cnt_d = 32'h0000_0000;
         step_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         step_cnt_q <= 32'h0000_0000;
         step_q <= 1'b0;
      end
      else if (ce)
      begin
         step_cnt_q <= step_cnt_d;
         step_q <= step_d;
      end
   end

   // register file next values: cruise steps first, software writes win
   always_comb
   begin
      cfg_d = cfg_q;
      tol_d = tol_q;
      for (int i = 0; i < 2; i++)
      begin
         drv_d[i] = drv_q[i];
         tgt_d[i] = tgt_q[i];
         flr_d[i] = flr_q[i];
         if (step_q && dir[i][1])
         begin
            // step up, saturate at full scale
            drv_d[i] = (drv_q[i] >= 8'hF0) ? 8'hFF : drv_q[i] + DRV_STEP; // R18
         end
         else if (step_q && dir[i][0])
         begin
            // step down, never below the floor value
            if ({1'b0, drv_q[i]} <= {1'b0, flr_q[i]} + {1'b0, DRV_STEP})
            begin
               drv_d[i] = flr_q[i]; // R13 R14 R18
            end
            else
            begin
               drv_d[i] = drv_q[i] - DRV_STEP; // R18
            end
         end
      end
      if (wr_hit(bus_req, ADDR_SYS_DRV))
      begin
         drv_d[0] = bus_req.wdata;
      end
      else if (wr_hit(bus_req, ADDR_CPU_DRV))
      begin
         drv_d[1] = bus_req.wdata;
      end
      else if (wr_hit(bus_req, ADDR_CFG))
      begin
         cfg_d = bus_req.wdata & CFG_MODE_MASK;
      end
      else if (wr_hit(bus_req, ADDR_SYS_TGT))
      begin
         tgt_d[0] = bus_req.wdata;
      end
      else if (wr_hit(bus_req, ADDR_CPU_TGT))
      begin
         tgt_d[1] = bus_req.wdata;
      end
      else if (wr_hit(bus_req, ADDR_TOL))
      begin
         tol_d = bus_req.wdata;
      end
      else if (wr_hit(bus_req, ADDR_SYS_FLOOR))
      begin
         flr_d[0] = bus_req.wdata;
      end
      else if (wr_hit(bus_req, ADDR_CPU_FLOOR))
      begin
         flr_d[1] = bus_req.wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cfg_q <= RST_CFG;
         tol_q <= RST_TOL;
         for (int i = 0; i < 2; i++)
         begin
            drv_q[i] <= RST_DRV; // R03
            tgt_q[i] <= RST_TGT;
            flr_q[i] <= RST_FLOOR;
         end
      end
      else if (ce)
      begin
         cfg_q <= cfg_d;
         tol_q <= tol_d;
         for (int i = 0; i < 2; i++)
         begin
            drv_q[i] <= drv_d[i];
            tgt_q[i] <= tgt_d[i];
            flr_q[i] <= flr_d[i];
         end
      end
   end

   // hot-at-full-drive timers and warning levels
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         warn_cnt_d[i] = 36'h0_0000_0000;
         warn_d[i] = 1'b0;
         if (hot[i])
         begin
            warn_cnt_d[i] = (warn_cnt_q[i] >= WARN_LAST) ? WARN_LAST : warn_cnt_q[i] + 36'h0_0000_0001;
            warn_d[i] = warn_cnt_q[i] >= WARN_LAST; // R16
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         warn_q <= 2'b00;
         for (int i = 0; i < 2; i++)
         begin
            warn_cnt_q[i] <= 36'h0_0000_0000;
         end
      end
      else if (ce)
      begin
         warn_q <= warn_d;
         for (int i = 0; i < 2; i++)
         begin
            warn_cnt_q[i] <= warn_cnt_d[i];
         end
      end
   end

   // read data and drive codes, registered
   always_comb
   begin
      rdata_d = 8'h00;
      if (!bus_req.rd)
      begin
         rdata_d = 8'h00;
      end
      else if (bus_req.addr == ADDR_SYS_DRV)
      begin
         rdata_d = drv_q[0];
      end
      else if (bus_req.addr == ADDR_CPU_DRV)
      begin
         rdata_d = drv_q[1];
      end
      else if (bus_req.addr == ADDR_CFG)
      begin
         rdata_d = cfg_q;
      end
      else if (bus_req.addr == ADDR_SYS_TGT)
      begin
         rdata_d = tgt_q[0];
      end
      else if (bus_req.addr == ADDR_CPU_TGT)
      begin
         rdata_d = tgt_q[1];
      end
      else if (bus_req.addr == ADDR_TOL)
      begin
         rdata_d = tol_q;
      end
      else if (bus_req.addr == ADDR_SYS_FLOOR)
      begin
         rdata_d = flr_q[0];
      end
      else if (bus_req.addr == ADDR_CPU_FLOOR)
      begin
         rdata_d = flr_q[1];
      end
      else if (bus_req.addr == ADDR_WARN)
      begin
         rdata_d = {6'h00, warn_q};
      end
      for (int i = 0; i < 2; i++)
      begin
         code_d[i] = drv_q[i][DRV_CODE_LSB +: 4]; // R01 R02 R17
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 8'h00;
         code_q[0] <= RST_DRV[7:4];
         code_q[1] <= RST_DRV[7:4];
      end
      else if (ce)
      begin
         rdata_q <= rdata_d;
         code_q[0] <= code_d[0];
         code_q[1] <= code_d[1];
      end
   end

   assign rdata = rdata_q;
   assign system_fan_drive = code_q[0];
   assign processor_fan_drive = code_q[1];
   assign system_fan_warn = warn_q[0];
   assign processor_fan_warn = warn_q[1];

   // checks
   property p_sys_drive;
      @(posedge clk_sys) disable iff (rst)
      ce |=> system_fan_drive == $past(drv_q[0][7:4]);
   endproperty
   a_sys_drive: assert property (p_sys_drive) else $error("system drive not from code bits"); // R01

   property p_cpu_drive;
      @(posedge clk_sys) disable iff (rst)
      ce |=> processor_fan_drive == $past(drv_q[1][7:4]);
   endproperty
   a_cpu_drive: assert property (p_cpu_drive) else $error("processor drive not from code bits"); // R02

   property p_reset_full;
      @(posedge clk_sys)
      $fell(rst) |-> (drv_q[0] == 8'hFF) && (drv_q[1] == 8'hFF) && (system_fan_drive == 4'hF);
   endproperty
   a_reset_full: assert property (p_reset_full) else $error("drive not full after reset"); // R03

   property p_manual_hold;
      @(posedge clk_sys) disable iff (rst)
      (ce && mode[0] == MODE_MANUAL && !bus_req.wr) |=> $stable(drv_q[0]);
   endproperty
   a_manual_hold: assert property (p_manual_hold) else $error("manual drive moved by itself"); // R17

   property p_rsvd_hold;
      @(posedge clk_sys) disable iff (rst)
      (ce && cfg_q[5:4] == 2'b11 && !bus_req.wr) |=> $stable(drv_q[1]);
   endproperty
   a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved mode changed drive"); // R06 R04

   property p_sys_floor;
      @(posedge clk_sys) disable iff (rst)
      (ce && step_q && mode[0] == MODE_THERMAL && dir[0] == 2'b01 && !bus_req.wr)
         |=> drv_q[0] >= $past(flr_q[0]);
   endproperty
   a_sys_floor: assert property (p_sys_floor) else $error("system drive below floor"); // R13

   property p_cpu_floor;
      @(posedge clk_sys) disable iff (rst)
      (ce && step_q && mode[1] == MODE_THERMAL && dir[1] == 2'b01 && !bus_req.wr)
         |=> drv_q[1] >= $past(flr_q[1]);
   endproperty
   a_cpu_floor: assert property (p_cpu_floor) else $error("processor drive below floor"); // R14

   property p_step_up;
      @(posedge clk_sys) disable iff (rst)
      (ce && step_q && dir[0][1] && drv_q[0] != 8'hFF && !bus_req.wr) |=> drv_q[0] > $past(drv_q[0]);
   endproperty
   a_step_up: assert property (p_step_up) else $error("cruise did not step up"); // R18

   property p_speed_full;
      @(posedge clk_sys) disable iff (rst)
      (mode[1] == MODE_SPEED && cpu_meas.tach > tgt_q[1] + {4'h0, tol_q[7:4]} && tgt_q[1] < 8'hF0) |-> dir[1] == 2'b10;
   endproperty
   a_speed_full: assert property (p_speed_full) else $error("speed cruise compare wrong"); // R10 R12

   property p_warn_time;
      @(posedge clk_sys) disable iff (rst)
      $rose(system_fan_warn) |-> $past(warn_cnt_q[0]) == WARN_LAST && $past(hot[0]);
   endproperty
   a_warn_time: assert property (p_warn_time) else $error("warning raised early"); // R16

   property p_cfg_read;
      @(posedge clk_sys) disable iff (rst)
      (ce && bus_req.rd && bus_req.addr == ADDR_CFG) |=> rdata == $past(cfg_q);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read wrong"); // R05

endmodule : fan_speed_control_regs

// *** include/fan_ctrl_pkg.sv ***
// Purpose: constants and types shared by the fan drive register bank
// Assumes: one clock at 250 MHz, byte-wide register port
// Notes: offsets are the register indices as seen on the plain port
package fan_ctrl_pkg;

   // register offsets
   localparam logic [7:0] ADDR_SYS_DRV = 8'h01;
   localparam logic [7:0] ADDR_CPU_DRV = 8'h03;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_SYS_TGT = 8'h05;
   localparam logic [7:0] ADDR_CPU_TGT = 8'h06;
   localparam logic [7:0] ADDR_TOL = 8'h07;
   localparam logic [7:0] ADDR_SYS_FLOOR = 8'h08;
   localparam logic [7:0] ADDR_CPU_FLOOR = 8'h09;
   localparam logic [7:0] ADDR_WARN = 8'h0B;

   // reset values
   localparam logic [7:0] RST_DRV = 8'hFF;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_TGT = 8'h00;
   localparam logic [7:0] RST_TOL = 8'h00;
   localparam logic [7:0] RST_FLOOR = 8'h01;

   // field positions
   localparam int DRV_CODE_LSB = 4;
   localparam int CFG_SYS_MODE_LSB = 2;
   localparam int TOL_SYS_LSB = 0;
   localparam logic [7:0] CFG_MODE_MASK = 8'h3C;
   localparam logic [7:0] DRV_STEP = 8'h10;
   localparam logic [3:0] CODE_FULL = 4'hF;

   // timing
   localparam longint CLK_HZ = 250_000_000;
   localparam longint STEP_TIME_US = 1000;
   localparam longint STEP_CYCLES_DEF = STEP_TIME_US * CLK_HZ / 1_000_000;
   localparam longint WARN_TIME_MIN = 3;
   localparam longint WARN_CYCLES_DEF = WARN_TIME_MIN * 60 * CLK_HZ;

   typedef enum logic [1:0] {
      MODE_MANUAL = 2'b00,
      MODE_THERMAL = 2'b01,
      MODE_SPEED = 2'b10,
      MODE_RSVD = 2'b11
   } fan_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [6:0] temp;
      logic [7:0] tach;
   } fan_meas_t;

endpackage : fan_ctrl_pkg

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the fan drive register bank
// Assumes: short step and warning counts so cruise runs in a few hundred cycles
// Notes: drives all inputs right after rising edges; one compare task for every result
`timescale 1ns/1ns
module tb
   import fan_ctrl_pkg::*;
;
   localparam longint STEP_N = 8;
   localparam longint WARN_N = 20;
   logic clk_sys;
   logic rst;
   logic ce;
   reg_req_t bus_req;
   fan_meas_t sys_meas;
   fan_meas_t cpu_meas;
   logic [7:0] rdata;
   logic [3:0] system_fan_drive;
   logic [3:0] processor_fan_drive;
   logic system_fan_warn;
   logic processor_fan_warn;
   int num_errors;
   int check_count;
   logic [7:0] rst_addr [10] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h02};
   logic [7:0] rst_val [10] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};

   fan_speed_control_regs #(
      .STEP_CYCLES(STEP_N),
      .WARN_CYCLES(WARN_N)
   ) fan_speed_control_regs_inst (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .bus_req(bus_req),
      .rdata(rdata),
      .sys_meas(sys_meas),
      .cpu_meas(cpu_meas),
      .system_fan_drive(system_fan_drive),
      .processor_fan_drive(processor_fan_drive),
      .system_fan_warn(system_fan_warn),
      .processor_fan_warn(processor_fan_warn)
   );

   // free-running 250 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // verdict and end of run
   task automatic conclude();
      if (num_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // byte compare, counts every check
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : chk

   // a bounded wait that ran out
   task automatic timed_out(input string name);
      $display("ERROR %s expected done seen timeout", name);
      num_errors++;
      conclude();
   endtask : timed_out

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask : rd_chk

   // measurement inputs for both fans
   task automatic set_meas(input logic [6:0] st, input logic [7:0] sa, input logic [6:0] ct, input logic [7:0] ca);
      @(posedge clk_sys);
      sys_meas <= '{temp: st, tach: sa};
      cpu_meas <= '{temp: ct, tach: ca};
   endtask : set_meas

   // wait until both codes settle on the expected values
   task automatic wait_codes(input logic [3:0] es, input logic [3:0] ec);
      int i;
      for (i = 0; i < 400; i++)
      begin
         if (system_fan_drive === es && processor_fan_drive === ec)
            break;
         @(posedge clk_sys);
         #1;
      end
      if (i == 400)
         timed_out("drive codes");
      chk("system code", {4'h0, es}, {4'h0, system_fan_drive});
      chk("processor code", {4'h0, ec}, {4'h0, processor_fan_drive});
   endtask : wait_codes

   // fixed number of cycles
   task automatic hold(input longint n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : hold

   // run limit
   initial
   begin
      #300000;
      timed_out("run");
   end

   // main sequence
   initial
   begin
      int i;
      rst = 1'b1;
      ce = 1'b1;
      bus_req = '0;
      sys_meas = '0;
      cpu_meas = '0;
      num_errors = 0;
      check_count = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      wait_codes(4'hF, 4'hF);
      // reset values, warning status and an unmapped place
      for (i = 0; i < 10; i++)
         rd_chk(rst_addr[i], rst_val[i], "reset value");
      wr(8'h02, 8'hA5);
      rd_chk(8'h02, 8'h00, "unmapped");
      // manual mode: codes applied as written, extreme inputs ignored
      set_meas(7'h7F, 8'hFF, 7'h7F, 8'hFF);
      wr(ADDR_SYS_DRV, 8'h80);
      wr(ADDR_CPU_DRV, 8'h50);
      hold(5 * STEP_N);
      wait_codes(4'h8, 4'h5);
      // reserved mode on both fans, reserved bits read zero
      wr(ADDR_CFG, 8'hFF);
      rd_chk(ADDR_CFG, 8'h3C, "fan mode config");
      hold(5 * STEP_N);
      wait_codes(4'h8, 4'h5);
      // a write with clock enable low is ignored
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(ADDR_SYS_DRV, 8'h00);
      ce <= 1'b1;
      rd_chk(ADDR_SYS_DRV, 8'h80, "system level");
      // thermal cruise down to the floors, target bit 7 ignored
      wr(ADDR_CFG, 8'h00);
      set_meas(7'h10, 8'h00, 7'h10, 8'h00);
      wr(ADDR_SYS_TGT, 8'hD0);
      wr(ADDR_CPU_TGT, 8'h50);
      wr(ADDR_TOL, 8'h21);
      wr(ADDR_SYS_FLOOR, 8'h30);
      wr(ADDR_CPU_FLOOR, 8'h40);
      wr(ADDR_CFG, 8'h14);
      wait_codes(4'h3, 4'h4);
      hold(4 * STEP_N);
      wait_codes(4'h3, 4'h4);
      rd_chk(ADDR_SYS_DRV, 8'h30, "system level");
      // thermal cruise up to full, then the hot warning
      set_meas(7'h60, 8'h00, 7'h60, 8'h00);
      wait_codes(4'hF, 4'hF);
      hold(WARN_N - 5);
      // processor fan climbs from a higher floor, so it reaches full one step earlier
      chk("early warn", 8'h02, {6'h0, processor_fan_warn, system_fan_warn});
      for (i = 0; i < 100 && !(system_fan_warn === 1'b1 && processor_fan_warn === 1'b1); i++)
         hold(1);
      if (i == 100)
         timed_out("warn");
      rd_chk(ADDR_WARN, 8'h03, "warn status");
      set_meas(7'h50, 8'h00, 7'h50, 8'h00);
      hold(3);
      chk("warn cleared", 8'h00, {6'h0, processor_fan_warn, system_fan_warn});
      // speed cruise: tolerance nibbles and full 8-bit targets
      wr(ADDR_CFG, 8'h00);
      wr(ADDR_SYS_DRV, 8'h80);
      wr(ADDR_CPU_DRV, 8'h80);
      wr(ADDR_TOL, 8'h5F);
      wr(ADDR_SYS_TGT, 8'h90);
      wr(ADDR_CPU_TGT, 8'h80);
      set_meas(7'h00, 8'h9A, 7'h00, 8'h7C);
      wr(ADDR_CFG, 8'h28);
      hold(5 * STEP_N);
      wait_codes(4'h8, 4'h8);
      set_meas(7'h00, 8'hC0, 7'h00, 8'h10);
      wait_codes(4'hF, 4'h4);
      // swap directions: system falls to its floor, processor climbs to full
      set_meas(7'h00, 8'h10, 7'h00, 8'hC0);
      wait_codes(4'h3, 4'hF);
      // second reset in mid-run
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      wait_codes(4'hF, 4'hF);
      rd_chk(ADDR_CFG, 8'h00, "fan mode config");
      rd_chk(ADDR_SYS_FLOOR, 8'h01, "system floor");
      conclude();
   end

endmodule : tb
